// ### hw/gi_i2c_cmd_slave.sv
`timescale 1ns/1ps
`include "gi_map.svh"

module gi_i2c_cmd_slave #(
    parameter int BUS_STUCK_CYCLES = `GI_BUS_STUCK_CYCLES,
    parameter int SETTLE_CYCLES = `GI_RELEASE_SETTLE_CYCLES,
    parameter logic [`GI_CMD_LOCS-1:0] RO_MASK = `GI_RO_MASK
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire gi_pkg::gi_wr_t core_wr,
    output gi_pkg::gi_wr_t host_wr,
    output logic [7:0] ptr,
    output logic sleep
);
    localparam int LOCS = `GI_CMD_LOCS;

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    wire rst_b_sync = rst_sync_q;

    // Pin synchronisers; the meta stage feeds only the sync stage
    gi_pkg::gi_lines_t pin_meta_q;
    gi_pkg::gi_lines_t pin_sync_q;
    gi_pkg::gi_lines_t pin_prev_q;

    always_ff @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
            pin_prev_q <= '1;
        end else begin
            pin_meta_q <= '{scl: scl_i, sda: sda_i};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    wire scl_s = pin_sync_q.scl;
    wire sda_s = pin_sync_q.sda;
    wire scl_rise = scl_s & ~pin_prev_q.scl;
    wire scl_fall = ~scl_s & pin_prev_q.scl;
    wire start_det = scl_s & pin_prev_q.scl & pin_prev_q.sda & ~sda_s;
    wire stop_det = scl_s & pin_prev_q.scl & ~pin_prev_q.sda & sda_s;

    // Bus-stuck watchdog
    logic release_p;
    logic sleep_w;

    gi_stuck_watch #(
        .TIMEOUT_CYCLES(BUS_STUCK_CYCLES),
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_watch (
        .clk(sys_clk),
        .rst_b(rst_b_sync),
        .lines(pin_sync_q),
        .release_q(release_p),
        .sleep_q(sleep_w)
    );

    function automatic logic loc_valid(input logic [7:0] a);
        loc_valid = a <= `GI_CMD_MAX;
    endfunction : loc_valid

    // Command locations
    logic [7:0] mem_q [0:LOCS-1];

    gi_pkg::gi_state_t state_q;
    gi_pkg::gi_state_t state_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic oe_q;
    logic oe_d;
    gi_pkg::gi_wr_t wr_q;
    gi_pkg::gi_wr_t wr_d;

    wire [6:0] ptr_idx = ptr_q[6:0];
    wire ptr_ok = loc_valid(ptr_q);
    // Past the last location a read returns zero instead of aliasing
    wire [7:0] rd_byte = ptr_ok ? mem_q[ptr_idx] : 8'h00;
    wire wr_ok = ptr_ok && !RO_MASK[ptr_idx];
    wire rx_done = scl_fall && (cnt_q == `GI_BYTE_BITS);
    wire addr_hit = (sh_q == `GI_ADDR_BYTE_WR) || (sh_q == `GI_ADDR_BYTE_RD);
    wire force_idle = release_p | sleep_w;

    always_comb begin
        state_d = state_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        wr_d = wr_q;
        wr_d.en = 1'b0;
        if (force_idle) begin
            state_d = gi_pkg::GI_IDLE;
            oe_d = 1'b0;
        end else if (start_det) begin
            // Also a repeated start in the middle of a transfer
            state_d = gi_pkg::GI_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop_det) begin
            state_d = gi_pkg::GI_IDLE;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                gi_pkg::GI_IDLE: begin
                    oe_d = 1'b0;
                end
                gi_pkg::GI_ADDR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (rx_done) begin
                        if (addr_hit) begin
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                            state_d = gi_pkg::GI_ADDR_ACK;
                        end else begin
                            state_d = gi_pkg::GI_IDLE;
                        end
                    end
                end
                gi_pkg::GI_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            // Read without command byte starts at the pointer
                            sh_d = rd_byte;
                            oe_d = ~rd_byte[7];
                            state_d = gi_pkg::GI_RDATA;
                        end else begin
                            oe_d = 1'b0;
                            state_d = gi_pkg::GI_CMD;
                        end
                    end
                end
                gi_pkg::GI_CMD: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (rx_done) begin
                        if (loc_valid(sh_q)) begin
                            oe_d = 1'b1;
                            ptr_d = sh_q;
                            state_d = gi_pkg::GI_CMD_ACK;
                        end else begin
                            oe_d = 1'b0;
                            state_d = gi_pkg::GI_IDLE;
                        end
                    end
                end
                gi_pkg::GI_CMD_ACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        state_d = gi_pkg::GI_WDATA;
                    end
                end
                gi_pkg::GI_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (rx_done) begin
                        if (wr_ok) begin
                            oe_d = 1'b1;
                            wr_d = '{en: 1'b1, addr: ptr_q, data: sh_q};
                            ptr_d = ptr_q + 8'h01;
                            state_d = gi_pkg::GI_WDATA_ACK;
                        end else begin
                            oe_d = 1'b0;
                            state_d = gi_pkg::GI_IDLE;
                        end
                    end
                end
                gi_pkg::GI_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        state_d = gi_pkg::GI_WDATA;
                    end
                end
                gi_pkg::GI_RDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == `GI_BYTE_BITS) begin
                            oe_d = 1'b0;
                            state_d = gi_pkg::GI_RDATA_ACK;
                        end else begin
                            oe_d = ~sh_q[7];
                        end
                    end
                end
                gi_pkg::GI_RDATA_ACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            ptr_d = ptr_q + 8'h01;
                            cnt_d = 4'h0;
                        end else begin
                            // Master NACK ends the read; wait for stop
                            state_d = gi_pkg::GI_IDLE;
                        end
                    end else if (scl_fall && cnt_q == 4'h0) begin
                        sh_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        state_d = gi_pkg::GI_RDATA;
                    end
                end
                default: begin
                    state_d = gi_pkg::GI_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            state_q <= gi_pkg::GI_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= '0;
        end else begin
            state_q <= state_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
        end
    end

    // Host write wins; a same-cycle core update of any location is dropped
    wire core_ok = core_wr.en && loc_valid(core_wr.addr);

    always_ff @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            for (int i = 0; i < LOCS; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr_d.en) begin
            mem_q[wr_d.addr[6:0]] <= wr_d.data;
        end else if (core_ok) begin
            mem_q[core_wr.addr[6:0]] <= core_wr.data;
        end
    end

    // Pin drivers; SCL is never stretched, so it only ever reads released
    logic scl_oe_q;
    logic sleep_q;

    always_ff @(posedge sys_clk or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            scl_oe_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            scl_oe_q <= 1'b0;
            sleep_q <= sleep_w;
        end
    end

    assign sda_oe = oe_q;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_q;
    assign scl_o = 1'b0;
    assign host_wr = wr_q;
    assign ptr = ptr_q;
    assign sleep = sleep_q;

endmodule : gi_i2c_cmd_slave

// ### hw/gi_map.svh
`ifndef GI_MAP_SVH
`define GI_MAP_SVH

`define GI_DEV_ADDR 7'h55
`define GI_ADDR_BYTE_WR 8'hAA
`define GI_ADDR_BYTE_RD 8'hAB
`define GI_CMD_MAX 8'h6B
`define GI_CMD_LOCS 108
`define GI_BYTE_BITS 4'h8

// Locations 02..3F hold gauge results and are read-only
`define GI_RO_MASK 108'h000_0000_0000_FFFF_FFFF_FFFF_FFFC

`define GI_CLK_PERIOD_NS 5
`define GI_BUS_STUCK_TIMEOUT_NS 2000000
`define GI_BUS_STUCK_CYCLES \
    ((`GI_BUS_STUCK_TIMEOUT_NS + `GI_CLK_PERIOD_NS - 1) / `GI_CLK_PERIOD_NS)
`define GI_RELEASE_SETTLE_CYCLES 4

`endif

// ### hw/gi_pkg.sv
package gi_pkg;

    typedef enum logic [3:0] {
        GI_IDLE      = 4'h0,
        GI_ADDR      = 4'h1,
        GI_ADDR_ACK  = 4'h3,
        GI_CMD       = 4'h2,
        GI_CMD_ACK   = 4'h6,
        GI_WDATA     = 4'h7,
        GI_WDATA_ACK = 4'h5,
        GI_RDATA     = 4'h4,
        GI_RDATA_ACK = 4'hC
    } gi_state_t;

    typedef enum logic [1:0] {
        GI_W_WATCH  = 2'h0,
        GI_W_SETTLE = 2'h1,
        GI_W_SLEEP  = 2'h3
    } gi_watch_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } gi_wr_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } gi_lines_t;

endpackage : gi_pkg

// ### hw/gi_stuck_watch.sv
`timescale 1ns/1ps
`include "gi_map.svh"

module gi_stuck_watch #(
    parameter int TIMEOUT_CYCLES = `GI_BUS_STUCK_CYCLES,
    parameter int SETTLE_CYCLES = `GI_RELEASE_SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire gi_pkg::gi_lines_t lines,
    output logic release_q,
    output logic sleep_q
);
    localparam int CW = $clog2(TIMEOUT_CYCLES + SETTLE_CYCLES + 1);

    gi_pkg::gi_watch_t st_q;
    gi_pkg::gi_watch_t st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic release_d;
    logic sleep_d;

    wire line_low = ~lines.scl | ~lines.sda;
    wire timeout_hit = cnt_q == CW'(TIMEOUT_CYCLES - 1);
    wire settle_hit = cnt_q == CW'(SETTLE_CYCLES - 1);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        release_d = 1'b0;
        sleep_d = sleep_q;
        case (st_q)
            gi_pkg::GI_W_WATCH: begin
                if (!line_low) begin
                    cnt_d = '0;
                end else if (timeout_hit) begin
                    release_d = 1'b1;
                    cnt_d = '0;
                    st_d = gi_pkg::GI_W_SETTLE;
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            gi_pkg::GI_W_SETTLE: begin
                // Lets our own release reach the synchronised pins first
                cnt_d = cnt_q + CW'(1);
                if (settle_hit) begin
                    cnt_d = '0;
                    if (line_low) begin
                        st_d = gi_pkg::GI_W_SLEEP;
                        sleep_d = 1'b1;
                    end else begin
                        st_d = gi_pkg::GI_W_WATCH;
                    end
                end
            end
            gi_pkg::GI_W_SLEEP: begin
                if (!line_low) begin
                    st_d = gi_pkg::GI_W_WATCH;
                    sleep_d = 1'b0;
                end
            end
            default: begin
                st_d = gi_pkg::GI_W_WATCH;
                cnt_d = '0;
                sleep_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= gi_pkg::GI_W_WATCH;
            cnt_q <= '0;
            release_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            release_q <= release_d;
            sleep_q <= sleep_d;
        end
    end

endmodule : gi_stuck_watch

// ### test/gi_cmd_checker.sv
`timescale 1ns/1ps
`include "gi_map.svh"

module gi_cmd_checker #(
    parameter int BUS_STUCK_CYCLES = 64,
    parameter int SETTLE_CYCLES = 4,
    parameter logic [`GI_CMD_LOCS-1:0] RO_MASK = `GI_RO_MASK
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire gi_pkg::gi_wr_t core_wr,
    input wire gi_pkg::gi_wr_t host_wr,
    input wire logic [7:0] ptr,
    input wire logic sleep
);
    // Raw pins lead the design's synced copy, so limits carry margin
    logic [19:0] low_cnt_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt_q <= 20'h0_0000;
        end else if (scl_i && sda_i) begin
            low_cnt_q <= 20'h0_0000;
        end else if (low_cnt_q != 20'hF_FFFF) begin
            low_cnt_q <= low_cnt_q + 20'h0_0001;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_scl_not_held: assert property (!scl_oe)
        else $error("device drives the clock line");
    chk_sda_pull_low: assert property (sda_oe |-> !sda_o)
        else $error("data line driven high");
    chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line moved while clock high");
    chk_wr_ptr_next: assert property (host_wr.en |-> ptr == host_wr.addr + 8'h01)
        else $error("pointer not one past written location");
    chk_wr_single: assert property (host_wr.en |=> (!host_wr.en) [*8])
        else $error("write pulses too close");
    chk_wr_acked: assert property (host_wr.en |-> ##[0:1] sda_oe)
        else $error("stored byte was not acknowledged");
    chk_wr_legal: assert property (host_wr.en |->
        host_wr.addr <= 8'h6B && !RO_MASK[host_wr.addr[6:0]])
        else $error("write to protected or absent location");
    chk_stuck_free: assert property (low_cnt_q >= BUS_STUCK_CYCLES + 6 |-> !sda_oe)
        else $error("data line held past bus timeout");
    chk_sleep_cause: assert property ($rose(sleep) |->
        low_cnt_q >= BUS_STUCK_CYCLES + SETTLE_CYCLES)
        else $error("sleep without stuck bus");
    chk_sleep_quiet: assert property (sleep |-> !sda_oe)
        else $error("driving while asleep");
endmodule : gi_cmd_checker

bind gi_i2c_cmd_slave gi_cmd_checker #(.BUS_STUCK_CYCLES(BUS_STUCK_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES), .RO_MASK(RO_MASK)) u_chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .core_wr(core_wr), .host_wr(host_wr),
    .ptr(ptr), .sleep(sleep));

// ### test/gi_host_model.sv
`timescale 1ns/1ps

module gi_host_model (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Six cycles a phase: above the engine's sampling minimum
    task automatic tick();
        repeat (6) @(posedge clk);
    endtask : tick
    task automatic start();
        sda_low <= 1'b0;
        tick();
        scl_low <= 1'b0;
        tick();
        sda_low <= 1'b1;
        tick();
        scl_low <= 1'b1;
        tick();
    endtask : start
    task automatic stop();
        sda_low <= 1'b1;
        tick();
        scl_low <= 1'b0;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick();
        scl_low <= 1'b0;
        tick();
        r = sda;
        scl_low <= 1'b1;
        tick();
    endtask : bit_io
    task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
                           output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(!m_ack, r);
        acked = !r;
    endtask : byte_io
    task automatic free_bus();
        sda_low <= 1'b0;
        tick();
        scl_low <= 1'b0;
        tick();
    endtask : free_bus
endmodule : gi_host_model

// ### test/gauge_i2c_command_slave_test.sv
`timescale 1ns/1ps
`include "gi_map.svh"

module gauge_i2c_command_slave_test;
    localparam int STUCK = 400;
    logic sys_clk = 1'b0;
    // Host side runs on its own clock, unrelated to the engine's
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    gi_pkg::gi_wr_t core_wr = '0;
    gi_pkg::gi_wr_t host_wr;
    logic scl_o, scl_oe, sda_o, sda_oe, sleep, m_scl_low, m_sda_low, ak;
    logic [7:0] ptr, q;
    wire scl_w = !(m_scl_low || (scl_oe && !scl_o));
    wire sda_w = !(m_sda_low || (sda_oe && !sda_o));
    int mismatches = 0;
    int cmp_count = 0;
    gi_pkg::gi_wr_t seen[$];

    always #2.5 sys_clk = !sys_clk;
    always #3 link_clk = !link_clk;

    gi_i2c_cmd_slave #(.BUS_STUCK_CYCLES(STUCK)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .core_wr(core_wr), .host_wr(host_wr), .ptr(ptr), .sleep(sleep));
    gi_host_model u_host (.clk(link_clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low),
        .sda_low(m_sda_low));

    always @(posedge sys_clk) begin
        if (host_wr.en === 1'b1) begin
            seen.push_back(host_wr);
        end
    end

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic send(input logic [7:0] d, input logic exp_ack);
        u_host.byte_io(d, 1'b0, q, ak);
        chk8("ack", {7'h00, exp_ack}, {7'h00, ak});
    endtask : send
    task automatic recv(input logic [7:0] exp, input logic more);
        u_host.byte_io(8'hFF, more, q, ak);
        chk8("read data", exp, q);
    endtask : recv
    // Bounded wait on the data drive (sel 0) or the sleep flag
    task automatic await(input int sel, input logic v, input int lim);
        int n;
        n = 0;
        while (((sel == 0) ? sda_oe : sleep) !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > lim) begin
                mismatches++;
                summarize();
            end
        end
    endtask : await

    task automatic t_reset();
        chk8("idle outputs", 8'h00, {2'h0, scl_o, sda_o, scl_oe, sda_oe, sleep, host_wr.en});
        chk8("pointer", 8'h00, ptr);
    endtask : t_reset
    task automatic t_foreign();
        u_host.start();
        send(8'h90, 1'b0);
        u_host.stop();
        u_host.start();
        send(8'hAC, 1'b0);
        u_host.stop();
    endtask : t_foreign
    task automatic t_write();
        u_host.start();
        send(`GI_ADDR_BYTE_WR, 1'b1);
        send(8'h00, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        u_host.stop();
        chk8("stores", 8'h02, 8'(seen.size()));
        chk8("store 0", 8'h12, (seen.size() > 0) ? seen[0].data : 8'hXX);
        chk8("store 1 at", 8'h01, (seen.size() > 1) ? seen[1].addr : 8'hXX);
        chk8("pointer", 8'h02, ptr);
        seen.delete();
    endtask : t_write
    task automatic t_read_cmd();
        u_host.start();
        send(`GI_ADDR_BYTE_WR, 1'b1);
        send(8'h00, 1'b1);
        u_host.start();
        send(`GI_ADDR_BYTE_RD, 1'b1);
        recv(8'h12, 1'b1);
        recv(8'h34, 1'b0);
        u_host.stop();
        chk8("pointer", 8'h01, ptr);
    endtask : t_read_cmd
    task automatic t_quick();
        u_host.start();
        send(`GI_ADDR_BYTE_RD, 1'b1);
        recv(8'h34, 1'b0);
        u_host.stop();
        chk8("pointer", 8'h01, ptr);
    endtask : t_quick
    task automatic t_readonly();
        @(posedge sys_clk);
        core_wr <= '{en: 1'b1, addr: 8'h02, data: 8'h5A};
        @(posedge sys_clk);
        core_wr.en <= 1'b0;
        u_host.start();
        send(`GI_ADDR_BYTE_WR, 1'b1);
        send(8'h02, 1'b1);
        send(8'h55, 1'b0);
        u_host.stop();
        chk8("stores", 8'h00, 8'(seen.size()));
        u_host.start();
        send(`GI_ADDR_BYTE_WR, 1'b1);
        send(8'h02, 1'b1);
        u_host.start();
        send(`GI_ADDR_BYTE_RD, 1'b1);
        recv(8'h5A, 1'b0);
        u_host.stop();
    endtask : t_readonly
    task automatic t_range();
        u_host.start();
        send(`GI_ADDR_BYTE_WR, 1'b1);
        send(8'h6C, 1'b0);
        u_host.stop();
        @(posedge sys_clk);
        core_wr <= '{en: 1'b1, addr: `GI_CMD_MAX, data: 8'hA5};
        @(posedge sys_clk);
        core_wr.en <= 1'b0;
        u_host.start();
        send(`GI_ADDR_BYTE_WR, 1'b1);
        send(`GI_CMD_MAX, 1'b1);
        u_host.start();
        send(`GI_ADDR_BYTE_RD, 1'b1);
        recv(8'hA5, 1'b1);
        // Next byte lies past the last location
        recv(8'h00, 1'b0);
        u_host.stop();
        chk8("pointer", 8'h6C, ptr);
    endtask : t_range
    // Clock held low by the host while the device acknowledges
    task automatic t_stuck();
        logic [7:0] b;
        b = `GI_ADDR_BYTE_WR;
        u_host.start();
        for (int i = 7; i >= 0; i--) begin
            u_host.bit_io(b[i], ak);
        end
        chk8("ack drive", 8'h01, {7'h00, sda_oe});
        await(0, 1'b0, STUCK + 200);
        chk8("released", 8'h00, {7'h00, sda_oe});
        await(1, 1'b1, 40);
        chk8("sleep", 8'h01, {7'h00, sleep});
        u_host.free_bus();
        await(1, 1'b0, 40);
        chk8("awake", 8'h00, {7'h00, sleep});
    endtask : t_stuck

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge sys_clk);
        t_reset();
        t_foreign();
        t_write();
        t_read_cmd();
        t_quick();
        t_stuck();
        t_quick();
        t_readonly();
        t_range();
        // Mid-run reset must clear the pointer again
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        rst_b <= 1'b1;
        repeat (8) @(posedge sys_clk);
        t_reset();
        summarize();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
endmodule : gauge_i2c_command_slave_test
